// [hdl/osm_consts.svh]
// Constants for the op sample memory capture block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef OSM_CONSTS_SVH
`define OSM_CONSTS_SVH

// Register select indices on the model-specific register port
`define OSM_SEL_W 2
`define OSM_IDX_DCRES 2'h0
`define OSM_IDX_LINAD 2'h1
`define OSM_IDX_PHYSAD 2'h2
`define OSM_IDX_BRTGT 2'h3

// Cache result register layout
`define OSM_LAT_W 16
`define OSM_LAT_LSB 32
`define OSM_BIT_PHYSV 18
`define OSM_BIT_LINV 17
`define OSM_BIT_LOCKED 15
`define OSM_BIT_UNCACHED 14
`define OSM_BIT_WRCOMB 13
`define OSM_BIT_MISALIGN 8
`define OSM_BIT_DCMISS 7
`define OSM_BIT_HIT1G 5
`define OSM_BIT_HIT2M 4
`define OSM_BIT_TLBMISS 2
`define OSM_BIT_STORE 1
`define OSM_BIT_LOAD 0
`define OSM_DCRES_MASK 64'h0000_FFFF_0006_E1B7
`define OSM_MEMFLAG_MASK 64'h0000_0000_0006_E1B4

// Physical address register layout
`define OSM_PHYS_W 52
`define OSM_PHYS_MASK 64'h000F_FFFF_FFFF_FFFF

// Reset value of every capture register
`define OSM_RESET_WORD 64'h0000_0000_0000_0000

`endif

// [hdl/osm_pkg.sv]
// Types shared by the op sample memory capture block.
// Assumes the constants header is on the include path.
`include "osm_consts.svh"

package osm_pkg;

    typedef logic [63:0] osm_word_type;
    typedef logic [`OSM_LAT_W-1:0] osm_latency_type;
    typedef logic [`OSM_SEL_W-1:0] osm_sel_type;

    // Outcome of one portion of a load or store
    typedef struct packed {
        logic lockedAccess;
        logic uncacheableAccess;
        logic writeCombiningAccess;
        logic misalignedPenalty;
        logic dcacheMiss;
        logic tlbHit1g;
        logic tlbHit2m;
        logic tlbMiss;
    } osm_mem_flags_type;

    // Retire-time information about the tagged op
    typedef struct packed {
        logic isLoad;
        logic isStore;
        logic linValid;
        logic physValid;
        logic [63:0] linAddr;
        logic [`OSM_PHYS_W-1:0] physAddr;
        logic isBranch;
        logic condNotTaken;
        logic [63:0] branchTarget;
        logic [63:0] fallThrough;
    } osm_op_event_type;

endpackage : osm_pkg

// [hdl/osm_miss_latency.sv]
// Data cache miss latency counter.
// Assumes start and done pulses come from logic on sys_clk.
`timescale 1ns/1ps
`include "osm_consts.svh"

module osm_miss_latency #(
    parameter int LAT_W = `OSM_LAT_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic missStart,
    input wire logic missDone,
    output logic [LAT_W-1:0] latency
);

    generate
        if (LAT_W < 1 || LAT_W > `OSM_LAT_W) begin : g_bad_width
            $error("osm_miss_latency: LAT_W out of range");
        end
    endgenerate

    logic active_q;
    logic active_d;
    logic [LAT_W-1:0] cnt_q;
    logic [LAT_W-1:0] cnt_d;
    logic [LAT_W-1:0] latency_q;
    logic [LAT_W-1:0] latency_d;
    logic [LAT_W-1:0] cntInc;
    logic cntFull;

    // Saturate rather than wrap, so a very long miss never reads as short
    assign cntFull = &cnt_q;
    assign cntInc = cntFull ? cnt_q : cnt_q + LAT_W'(1);
    assign active_d = missStart ? !missDone : (active_q && !missDone);
    assign cnt_d = missStart ? '0 : (active_q ? cntInc : cnt_q);
    assign latency_d = (missStart && missDone) ? '0 :
                       (active_q && missDone) ? cntInc : latency_q;
    assign latency = latency_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            active_q <= 1'h0;
            cnt_q <= '0;
            latency_q <= '0;
        end else begin
            active_q <= active_d;
            cnt_q <= cnt_d;
            latency_q <= latency_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_latency_four: assert property (
        missStart && !missDone ##1 (!missStart && !missDone) [*3]
        ##1 (missDone && !missStart) |=> latency == LAT_W'(4))
        else $error("miss latency not four after four cycles");

    c_latency_seen: cover property (active_q && missDone);

endmodule : osm_miss_latency

// [hdl/osm_sample_capture.sv]
// Capture registers for the memory and branch results of a tagged op.
// Assumes the core drives all event inputs from logic on sys_clk,
// and that the sampling control logic owns the valid clear request.
//
// Summary of operation
// - Report only the portion below 128-bit boundary
// - Count cycles from miss detect to delivery
// - Miss latency undefined for store ops
// - Bit 18 marks physical address valid
// - Bit 17 marks linear address valid
// - Bit 15 marks a locked access
// - Bit 14 marks uncacheable memory access
// - Bit 13 marks write-combining memory access
// - Bit 8 marks misaligned access penalty
// - Bit 7 marks data cache miss
// - Bit 5 marks TLB hit, 1G page
// - Bit 4 marks TLB hit, 2M page
// - Bit 2 marks first-level TLB miss
// - Bits 1/0 store/load; reserved bits zero
// - Capture full 64-bit canonical linear operand
// - Physical address in 51:0, upper zero
// - Capture branch target; non-zero means valid
// - Not-taken conditional branch records fall-through address
// - Retire sets valid flag, halting interval counter
// - Aborted tagged op captures nothing
`timescale 1ns/1ps
`include "osm_consts.svh"

module osm_sample_capture #(
    parameter int LAT_W = `OSM_LAT_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire osm_pkg::osm_op_event_type opEvent,
    input wire logic tagRetire,
    input wire logic tagAbort,
    input wire logic memReport,
    input wire logic memAboveBoundary,
    input wire osm_pkg::osm_mem_flags_type memFlags,
    input wire logic missStart,
    input wire logic missDone,
    input wire logic missAboveBoundary,
    input wire logic sampleValidClear,
    input wire osm_pkg::osm_sel_type msrSel,
    input wire logic msrWrite,
    input wire logic msrRead,
    input wire osm_pkg::osm_word_type msrWdata,
    output osm_pkg::osm_word_type msrRdata,
    output logic msrAck,
    output logic sampleValidFlag,
    output logic opCounterStop
);

    generate
        if (LAT_W < 1 || LAT_W > `OSM_LAT_W) begin : g_bad_width
            $error("osm_sample_capture: LAT_W out of range");
        end
    endgenerate

    // Registers
    osm_pkg::osm_word_type dcres_q;
    osm_pkg::osm_word_type dcres_d;
    osm_pkg::osm_word_type linAd_q;
    osm_pkg::osm_word_type linAd_d;
    osm_pkg::osm_word_type physAd_q;
    osm_pkg::osm_word_type physAd_d;
    osm_pkg::osm_word_type brTgt_q;
    osm_pkg::osm_word_type brTgt_d;
    osm_pkg::osm_word_type rdata_q;
    osm_pkg::osm_word_type rdata_d;
    osm_pkg::osm_mem_flags_type pend_q;
    osm_pkg::osm_mem_flags_type pend_d;
    logic valid_q;
    logic valid_d;
    logic ack_q;

    // Latency counter, fed only by misses below the boundary
    logic lowMissStart;
    logic lowMissDone;
    logic [LAT_W-1:0] missLatency;

    assign lowMissStart = missStart && !missAboveBoundary;
    assign lowMissDone = missDone && !missAboveBoundary;

    osm_miss_latency #(
        .LAT_W(LAT_W)
    ) u_miss_latency (
        .sys_clk(sys_clk),
        .rst(rst),
        .missStart(lowMissStart),
        .missDone(lowMissDone),
        .latency(missLatency)
    );

    // Portion flags: the upper part of a straddling access is dropped
    logic lowReport;
    logic capture;
    logic isMem;
    osm_pkg::osm_mem_flags_type curFlags;
    osm_pkg::osm_mem_flags_type useFlags;

    assign lowReport = memReport && !memAboveBoundary;
    assign curFlags = lowReport ? memFlags : pend_q;
    // A second sample cannot land on unread data; abort wins over retire
    assign capture = tagRetire && !tagAbort && !valid_q;
    assign isMem = opEvent.isLoad || opEvent.isStore;
    assign useFlags = isMem ? curFlags : '0;
    assign pend_d = (capture || tagAbort) ? '0 : curFlags;

    // Cache result word as captured
    osm_pkg::osm_latency_type latField;
    osm_pkg::osm_word_type capWord;
    logic physV;
    logic linV;

    // Stores may carry a count left over from an earlier load miss
    assign latField = (isMem && useFlags.dcacheMiss) ?
                      osm_pkg::osm_latency_type'(missLatency) : '0;
    assign physV = isMem && opEvent.physValid;
    assign linV = isMem && opEvent.linValid;
    assign capWord = {
        16'h0000,
        latField,
        13'h0000,
        physV,
        linV,
        1'h0,
        useFlags.lockedAccess,
        useFlags.uncacheableAccess,
        useFlags.writeCombiningAccess,
        4'h0,
        useFlags.misalignedPenalty,
        useFlags.dcacheMiss,
        1'h0,
        useFlags.tlbHit1g,
        useFlags.tlbHit2m,
        1'h0,
        useFlags.tlbMiss,
        opEvent.isStore,
        opEvent.isLoad
    };

    // Address and target words as captured
    osm_pkg::osm_word_type capLin;
    osm_pkg::osm_word_type capPhys;
    osm_pkg::osm_word_type capBr;

    assign capLin = isMem ? opEvent.linAddr : '0;
    assign capPhys = isMem ? 64'(opEvent.physAddr) : '0;
    assign capBr = !opEvent.isBranch ? '0 :
                   opEvent.condNotTaken ? opEvent.fallThrough :
                   opEvent.branchTarget;

    // Software access decode; a retire capture beats a write
    logic wrDcres;
    logic wrLin;
    logic wrPhys;
    logic wrBr;

    assign wrDcres = msrWrite && (msrSel == `OSM_IDX_DCRES);
    assign wrLin = msrWrite && (msrSel == `OSM_IDX_LINAD);
    assign wrPhys = msrWrite && (msrSel == `OSM_IDX_PHYSAD);
    assign wrBr = msrWrite && (msrSel == `OSM_IDX_BRTGT);

    assign dcres_d = capture ? capWord :
                     wrDcres ? (msrWdata & `OSM_DCRES_MASK) : dcres_q;
    assign linAd_d = capture ? capLin : (wrLin ? msrWdata : linAd_q);
    assign physAd_d = capture ? capPhys :
                      wrPhys ? (msrWdata & `OSM_PHYS_MASK) : physAd_q;
    assign brTgt_d = capture ? capBr : (wrBr ? msrWdata : brTgt_q);

    // Hardware set wins over a clear in the same cycle
    assign valid_d = capture || (valid_q && !sampleValidClear);

    osm_pkg::osm_word_type rdSel;

    assign rdSel = (msrSel == `OSM_IDX_DCRES) ? dcres_q :
                   (msrSel == `OSM_IDX_LINAD) ? linAd_q :
                   (msrSel == `OSM_IDX_PHYSAD) ? physAd_q : brTgt_q;
    assign rdata_d = msrRead ? rdSel : rdata_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dcres_q <= `OSM_RESET_WORD;
            linAd_q <= `OSM_RESET_WORD;
            physAd_q <= `OSM_RESET_WORD;
            brTgt_q <= `OSM_RESET_WORD;
            rdata_q <= `OSM_RESET_WORD;
            pend_q <= '0;
            valid_q <= 1'h0;
            ack_q <= 1'h0;
        end else begin
            dcres_q <= dcres_d;
            linAd_q <= linAd_d;
            physAd_q <= physAd_d;
            brTgt_q <= brTgt_d;
            rdata_q <= rdata_d;
            pend_q <= pend_d;
            valid_q <= valid_d;
            ack_q <= msrRead || msrWrite;
        end
    end

    assign msrRdata = rdata_q;
    assign msrAck = ack_q;
    assign sampleValidFlag = valid_q;
    // The interval counter stays frozen while unread data is held
    assign opCounterStop = valid_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_retire_sets_valid: assert property (
        tagRetire && !tagAbort && !valid_q |=> sampleValidFlag
        && opCounterStop)
        else $error("retire did not set the sample valid flag");

    a_valid_holds: assert property (
        sampleValidFlag && !sampleValidClear |=> sampleValidFlag)
        else $error("sample valid flag dropped without a clear");

    a_abort_no_capture: assert property (
        tagAbort && !valid_q && !msrWrite |=>
        !sampleValidFlag && $stable(dcres_q) && $stable(brTgt_q))
        else $error("aborted op produced a sample");

    a_phys_valid_bit: assert property (
        capture |=> dcres_q[`OSM_BIT_PHYSV] ==
        $past(isMem && opEvent.physValid))
        else $error("physical valid bit does not follow the op");

    a_lin_valid_bit: assert property (
        capture |=> dcres_q[`OSM_BIT_LINV] ==
        $past(isMem && opEvent.linValid)
        && linAd_q == $past(capLin))
        else $error("linear valid bit or address wrong");

    a_load_store_bits: assert property (
        capture |=> dcres_q[`OSM_BIT_STORE] == $past(opEvent.isStore)
        && dcres_q[`OSM_BIT_LOAD] == $past(opEvent.isLoad))
        else $error("load or store bit wrong");

    a_reserved_zero: assert property (
        (dcres_q & ~`OSM_DCRES_MASK) == '0)
        else $error("reserved cache result bits not zero");

    a_nomem_clear: assert property (
        capture && !isMem |=> (dcres_q & `OSM_MEMFLAG_MASK) == '0)
        else $error("non-memory op left memory flags set");

    a_phys_upper_zero: assert property (
        physAd_q[63:`OSM_PHYS_W] == '0)
        else $error("physical address upper bits not zero");

    a_fall_through: assert property (
        capture && opEvent.isBranch && opEvent.condNotTaken |=>
        brTgt_q == $past(opEvent.fallThrough))
        else $error("not-taken branch lacks fall-through address");

    a_upper_dropped: assert property (
        memReport && memAboveBoundary && !capture && !tagAbort |=>
        pend_q == $past(pend_q))
        else $error("upper portion of access was recorded");

    // Each outcome flag lands at its own bit of the cache result word
    a_locked_bit: assert property (
        capture |=> dcres_q[`OSM_BIT_LOCKED] ==
        $past(useFlags.lockedAccess))
        else $error("locked access bit wrong");

    a_uncacheable_bit: assert property (
        capture |=> dcres_q[`OSM_BIT_UNCACHED] ==
        $past(useFlags.uncacheableAccess))
        else $error("uncacheable access bit wrong");

    a_write_combining_bit: assert property (
        capture |=> dcres_q[`OSM_BIT_WRCOMB] ==
        $past(useFlags.writeCombiningAccess))
        else $error("write-combining access bit wrong");

    a_misaligned_bit: assert property (
        capture |=> dcres_q[`OSM_BIT_MISALIGN] ==
        $past(useFlags.misalignedPenalty))
        else $error("misaligned penalty bit wrong");

    a_dcache_miss_bit: assert property (
        capture |=> dcres_q[`OSM_BIT_DCMISS] ==
        $past(useFlags.dcacheMiss))
        else $error("data cache miss bit wrong");

    a_tlb_1g_bit: assert property (
        capture |=> dcres_q[`OSM_BIT_HIT1G] ==
        $past(useFlags.tlbHit1g))
        else $error("large page hit bit wrong");

    a_tlb_2m_bit: assert property (
        capture |=> dcres_q[`OSM_BIT_HIT2M] ==
        $past(useFlags.tlbHit2m))
        else $error("medium page hit bit wrong");

    a_tlb_miss_bit: assert property (
        capture |=> dcres_q[`OSM_BIT_TLBMISS] ==
        $past(useFlags.tlbMiss))
        else $error("translation miss bit wrong");

    a_latency_field: assert property (
        capture && useFlags.dcacheMiss |=>
        dcres_q[`OSM_LAT_LSB +: `OSM_LAT_W] ==
        $past(osm_pkg::osm_latency_type'(missLatency)))
        else $error("miss latency field wrong");

    a_branch_target: assert property (
        capture && opEvent.isBranch && !opEvent.condNotTaken |=>
        brTgt_q == $past(opEvent.branchTarget))
        else $error("taken branch target not captured");

    a_abort_clears: assert property (
        tagAbort |=> pend_q == '0)
        else $error("abort left portion flags pending");

    a_valid_clear: assert property (
        sampleValidClear && valid_q |=> !sampleValidFlag)
        else $error("sample valid flag survived a clear");

    // Register port answers one cycle after every strobe
    a_ack_follows: assert property (
        msrRead || msrWrite |=> msrAck)
        else $error("register access not acknowledged");

    a_read_data: assert property (
        msrRead && msrSel == `OSM_IDX_LINAD |=>
        msrRdata == $past(linAd_q))
        else $error("read data does not match linear register");

    a_write_lands: assert property (
        msrWrite && !capture && msrSel == `OSM_IDX_LINAD |=>
        linAd_q == $past(msrWdata))
        else $error("linear register write lost");

    c_load_capture: cover property (capture && opEvent.isLoad);
    c_abort_seen: cover property (tagAbort && !valid_q);
    c_straddle: cover property (memReport && memAboveBoundary ##[1:4]
        capture);
    c_not_taken: cover property (capture && opEvent.condNotTaken);

endmodule : osm_sample_capture

// [dv/osm_core_model.sv]
// Behavioural core pipeline and load/store unit facing the capture block.
// Assumes the bench calls its tasks one at a time on sys_clk.
`timescale 1ns/1ps

module osm_core_model (
    input wire logic sys_clk,
    output osm_pkg::osm_op_event_type opEvent,
    output logic tagRetire,
    output logic tagAbort,
    output logic memReport,
    output logic memAboveBoundary,
    output osm_pkg::osm_mem_flags_type memFlags,
    output logic missStart,
    output logic missDone,
    output logic missAboveBoundary
);
    initial begin
        opEvent = '0;
        tagRetire = 1'h0;
        tagAbort = 1'h0;
        memReport = 1'h0;
        memAboveBoundary = 1'h0;
        memFlags = '0;
        missStart = 1'h0;
        missDone = 1'h0;
        missAboveBoundary = 1'h0;
    end

    // Qualifiers turn to garbage once their strobe drops, as on real logic
    task automatic portion(input osm_pkg::osm_mem_flags_type f,
                           input logic above);
        @(posedge sys_clk);
        memReport <= 1'h1;
        memFlags <= f;
        memAboveBoundary <= above;
        @(posedge sys_clk);
        memReport <= 1'h0;
        memFlags <= ~f;
        memAboveBoundary <= ~above;
    endtask : portion

    // Miss detected, data delivered n cycles later
    task automatic miss(input int n, input logic above);
        @(posedge sys_clk);
        missStart <= 1'h1;
        missAboveBoundary <= above;
        @(posedge sys_clk);
        missStart <= 1'h0;
        repeat (n - 1) @(posedge sys_clk);
        missDone <= 1'h1;
        @(posedge sys_clk);
        missDone <= 1'h0;
        missAboveBoundary <= ~above;
    endtask : miss

    task automatic retire(input osm_pkg::osm_op_event_type ev,
                          input logic abort);
        @(posedge sys_clk);
        opEvent <= ev;
        tagRetire <= 1'h1;
        tagAbort <= abort;
        @(posedge sys_clk);
        tagRetire <= 1'h0;
        tagAbort <= 1'h0;
        opEvent <= ~ev;
    endtask : retire
endmodule : osm_core_model

// [dv/osm_sample_capture_tb.sv]
// Self-checking bench for the op sample capture block.
// Assumes the core model and the design package are compiled first.
`timescale 1ns/1ps
`include "osm_consts.svh"

module osm_sample_capture_tb;
    localparam logic [63:0] LIN1 = 64'hFFFF_8000_0000_1230;
    localparam logic [63:0] LIN2 = 64'h0000_1234_5678_9ABC;
    localparam logic [63:0] TGT = 64'h0000_7FFF_0000_4000;
    localparam logic [63:0] NOLAT = ~64'h0000_FFFF_0000_0000;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic sampleValidClear = 1'h0;
    logic msrWrite = 1'h0;
    logic msrRead = 1'h0;
    osm_pkg::osm_sel_type msrSel = '0;
    osm_pkg::osm_word_type msrWdata = '0;
    osm_pkg::osm_word_type msrRdata;
    logic msrAck, sampleValidFlag, opCounterStop;
    osm_pkg::osm_op_event_type opEvent;
    osm_pkg::osm_mem_flags_type memFlags;
    logic tagRetire, tagAbort, memReport, memAboveBoundary;
    logic missStart, missDone, missAboveBoundary;
    int errTotal = 0;
    int compares = 0;

    always #5 sys_clk = ~sys_clk;

    osm_core_model u_osm_core_model (.sys_clk(sys_clk), .opEvent(opEvent),
        .tagRetire(tagRetire), .tagAbort(tagAbort), .memReport(memReport),
        .memAboveBoundary(memAboveBoundary), .memFlags(memFlags),
        .missStart(missStart), .missDone(missDone),
        .missAboveBoundary(missAboveBoundary));

    osm_sample_capture u_osm_sample_capture (.sys_clk(sys_clk), .rst(rst),
        .opEvent(opEvent), .tagRetire(tagRetire), .tagAbort(tagAbort),
        .memReport(memReport), .memAboveBoundary(memAboveBoundary),
        .memFlags(memFlags), .missStart(missStart), .missDone(missDone),
        .missAboveBoundary(missAboveBoundary),
        .sampleValidClear(sampleValidClear), .msrSel(msrSel),
        .msrWrite(msrWrite), .msrRead(msrRead), .msrWdata(msrWdata),
        .msrRdata(msrRdata), .msrAck(msrAck),
        .sampleValidFlag(sampleValidFlag), .opCounterStop(opCounterStop));

    // k = load, store, linear valid, physical valid, branch, not taken
    function automatic osm_pkg::osm_op_event_type mkEv(input logic [5:0] k,
        input logic [63:0] a, input logic [63:0] t);
        mkEv = {k[5:2], a, ~a[51:0], k[1:0], t, ~t};
    endfunction : mkEv

    // v = load, store, linear valid, physical valid
    function automatic osm_pkg::osm_word_type dcres(
        input osm_pkg::osm_mem_flags_type f, input logic [3:0] v,
        input logic [15:0] lat);
        dcres = {16'h0000, lat, 13'h0000, v[0], v[1], 1'h0, f[7:5], 4'h0,
                 f[4:3], 1'h0, f[2:1], 1'h0, f[0], v[2], v[3]};
    endfunction : dcres

    task automatic chkWord(input osm_pkg::osm_word_type e,
                           input osm_pkg::osm_word_type g);
        compares++;
        if (g !== e) begin
            errTotal++;
            $display("MISMATCH %0t word exp %h got %h", $time, e, g);
        end
    endtask : chkWord

    task automatic chkBit(input logic e, input logic g);
        compares++;
        if (g !== e) begin
            errTotal++;
            $display("MISMATCH %0t bit exp %b got %b", $time, e, g);
        end
    endtask : chkBit

    // Ack is due exactly one cycle after the strobe, so no wait loop
    task automatic rdChk(input osm_pkg::osm_sel_type sel,
        input osm_pkg::osm_word_type e, input osm_pkg::osm_word_type m = '1);
        @(posedge sys_clk);
        msrSel <= sel;
        msrRead <= 1'h1;
        @(posedge sys_clk);
        msrRead <= 1'h0;
        #1 chkBit(1'h1, msrAck);
        chkWord(e & m, msrRdata & m);
    endtask : rdChk

    task automatic wrReg(input osm_pkg::osm_sel_type sel,
                         input osm_pkg::osm_word_type d);
        @(posedge sys_clk);
        msrSel <= sel;
        msrWdata <= d;
        msrWrite <= 1'h1;
        @(posedge sys_clk);
        msrWrite <= 1'h0;
        msrWdata <= ~d;
        #1 chkBit(1'h1, msrAck);
    endtask : wrReg

    task automatic clearValid;
        @(posedge sys_clk);
        sampleValidClear <= 1'h1;
        @(posedge sys_clk);
        sampleValidClear <= 1'h0;
        #1 chkBit(1'h0, sampleValidFlag);
    endtask : clearValid

    task automatic scnReset;
        for (int s = 0; s < 4; s++) rdChk(s[1:0], '0);
        chkBit(1'h0, sampleValidFlag);
    endtask : scnReset

    // Upper portion and its miss carry different values that must not show
    task automatic scnLoad;
        u_osm_core_model.miss(5, 1'h0);
        u_osm_core_model.miss(9, 1'h1);
        u_osm_core_model.portion(8'hAA, 1'h0);
        u_osm_core_model.portion(8'h55, 1'h1);
        u_osm_core_model.retire(mkEv(6'h28, LIN1, TGT), 1'h0);
        #1 chkBit(1'h1, sampleValidFlag);
        chkBit(1'h1, opCounterStop);
        rdChk(2'h0, dcres(8'hAA, 4'hA, 16'h0005));
        rdChk(2'h1, LIN1);
        rdChk(2'h3, '0);
    endtask : scnLoad

    task automatic scnStore;
        clearValid();
        u_osm_core_model.portion(8'h55, 1'h0);
        u_osm_core_model.portion(8'hAA, 1'h1);
        u_osm_core_model.retire(mkEv(6'h1C, LIN2, '0), 1'h0);
        rdChk(2'h0, dcres(8'h55, 4'h7, 16'h0000), NOLAT);
        rdChk(2'h2, {12'h000, ~LIN2[51:0]});
    endtask : scnStore

    task automatic scnBlock;
        u_osm_core_model.retire(mkEv(6'h28, LIN1, '0), 1'h0);
        rdChk(2'h1, LIN2);
        clearValid();
        u_osm_core_model.retire(mkEv(6'h28, LIN1, '0), 1'h1);
        #1 chkBit(1'h0, sampleValidFlag);
        rdChk(2'h1, LIN2);
    endtask : scnBlock

    // A stale portion report must not leak into a branch sample
    task automatic scnBranch;
        u_osm_core_model.portion(8'hAA, 1'h0);
        u_osm_core_model.retire(mkEv(6'h02, LIN1, TGT), 1'h0);
        for (int s = 0; s < 3; s++) rdChk(s[1:0], '0);
        rdChk(2'h3, TGT);
        clearValid();
        u_osm_core_model.retire(mkEv(6'h03, LIN1, TGT), 1'h0);
        rdChk(2'h3, ~TGT);
        clearValid();
    endtask : scnBranch

    // A four-cycle miss is the exact case the counter's own check expects
    task automatic scnLatency;
        u_osm_core_model.miss(4, 1'h0);
        u_osm_core_model.portion(8'h08, 1'h0);
        u_osm_core_model.retire(mkEv(6'h20, LIN2, TGT), 1'h0);
        rdChk(2'h0, dcres(8'h08, 4'h8, 16'h0004));
        rdChk(2'h3, '0);
        clearValid();
    endtask : scnLatency

    task automatic scnSoftware;
        wrReg(2'h0, '1);
        rdChk(2'h0, `OSM_DCRES_MASK);
        wrReg(2'h2, '1);
        rdChk(2'h2, `OSM_PHYS_MASK);
        wrReg(2'h1, LIN2);
        rdChk(2'h1, LIN2);
        wrReg(2'h3, TGT);
        rdChk(2'h3, TGT);
    endtask : scnSoftware

    task automatic results;
        $display("Compares %0d mismatches %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'h0;
        scnReset();
        scnLoad();
        scnStore();
        scnBlock();
        scnBranch();
        scnLatency();
        scnSoftware();
        results();
    end
endmodule : osm_sample_capture_tb
